// *** cdsp_port.sv ***
`timescale 1ns/1ps
`include "cdsp_map.svh"
////////////////////////////////////////////////////////////////////////////////
// Small FIFO with valid/ready on both sides
module cdsp_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 4
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  wire push = in_valid_in && in_ready_out;
  wire pop = out_valid_out && out_ready_in;
  assign in_ready_out = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_out = (cnt_q != '0);
  assign out_data_out = mem_q[rd_q];
  // Pointers and occupancy
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
      if (pop) rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
  // Storage
  always_ff @(posedge clk_in) begin
    if (push) mem_q[wr_q] <= in_data_in;
  end
endmodule : cdsp_fifo

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RULE1: Serial input bit shifts in on every serial clock rising edge, up to 30 MHz; code loads the readback word instead on a load_req edge.
// RULE2: Host keeps serial input stable and valid around each serial clock rising edge.
// RULE3: Latch rising edge commits the whole shift register and updates the output.
// RULE4: Readback and daisy-chain modes drive next output bit on serial clock falling edge.
// RULE5: Clear high forces output to range low end within 5 us.
// RULE6: Open-drain fault pulls low on open loop in current mode or overtemperature; code gates open loop by output enable, not by range.
// RULE7: Host holds latch high 5 us after a control register write.
// RULE8: Readback output goes high impedance within 33 ns of latch rising edge.
// RULE9: Frame is 24 bits MSB first: 8 address bits then 16 data bits.
// RULE10: Address decode: NOP, data write, readback, control write, reset write.
// RULE11: Shifting ignores latch level; latch edge commits the last 24 bits.
// RULE12: Host keeps latch low while shifting, raises it after the last edge.
module cdsp_port
  import cdsp_pkg::*;
#(
  parameter int CLEAR_CYC = `CDSP_CLEAR_ACT_CYC
) (
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  input wire logic serial_clk_in,
  input wire logic serial_in_line_in,
  input wire logic latch_in,
  input wire logic clear_in,
  input wire logic open_loop_in,
  input wire logic overtemp_in,
  output logic serial_out_line_out,
  output logic serial_out_line_oe_out,
  output logic fault_n_out,
  output logic fault_n_oe_out,
  output logic [`CDSP_DATA_BITS-1:0] dac_code_out,
  output logic [2:0] range_out,
  output logic out_enable_out,
  output logic overflow_out
);
  ////////////////////////////////////////////////////////////////////////////
  // Link side, serial clock domain
  logic [`CDSP_FRAME_BITS-1:0] shift_q;
  logic sdo_bit_q;
  logic sdo_oe_q;
  logic [1:0] mode_sync_q;
  logic [2:0] load_sync_q;
  logic rb_tgl_q;
  logic [`CDSP_DATA_BITS-1:0] rb_word_q;
  cdsp_mode_type mode_q;
  wire load_req = load_sync_q[2] ^ load_sync_q[1];

  // RULE1 shift on rise
  // RULE11 shift regardless of latch
  always_ff @(posedge serial_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      shift_q <= '0;
      load_sync_q <= '0;
    end else begin
      load_sync_q <= {load_sync_q[1], load_sync_q[0], rb_tgl_q};
      if (load_req) shift_q <= {`CDSP_ADDR_BITS'(0), rb_word_q};
      else shift_q <= {shift_q[`CDSP_FRAME_BITS-2:0], serial_in_line_in};
    end
  end

  // RULE4 drive on fall
  always_ff @(negedge serial_clk_in or negedge nrst_in) begin
    if (!nrst_in) sdo_bit_q <= 1'b0;
    else sdo_bit_q <= shift_q[`CDSP_FRAME_BITS-1];
  end

  // Mode level into link domain
  always_ff @(negedge serial_clk_in or negedge nrst_in) begin
    if (!nrst_in) mode_sync_q <= '0;
    else mode_sync_q <= {mode_sync_q[0], mode_q != MODE_WRITE};
  end

  // RULE8 latch releases driver at once
  always_ff @(negedge serial_clk_in or negedge nrst_in or posedge latch_in) begin
    if (!nrst_in) sdo_oe_q <= 1'b0;
    else if (latch_in) sdo_oe_q <= 1'b0;
    else sdo_oe_q <= mode_sync_q[1];
  end
  assign serial_out_line_out = sdo_bit_q;
  assign serial_out_line_oe_out = sdo_oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers, system clock domain
  logic [2:0] latch_sync_q;
  logic [1:0] clear_sync_q;
  logic [1:0] oc_sync_q;
  logic [1:0] ot_sync_q;
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      latch_sync_q <= '0;
      clear_sync_q <= '0;
      oc_sync_q <= '0;
      ot_sync_q <= '0;
    end else begin
      latch_sync_q <= {latch_sync_q[1:0], latch_in};
      clear_sync_q <= {clear_sync_q[0], clear_in};
      oc_sync_q <= {oc_sync_q[0], open_loop_in};
      ot_sync_q <= {ot_sync_q[0], overtemp_in};
    end
  end
  wire latch_edge = latch_sync_q[1] && !latch_sync_q[2];
  wire clear_s = clear_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Capture on latch edge, then queue
  logic pend_q;
  logic ovf_q;
  cdsp_frame_type cap_q;
  cdsp_frame_type pop_word;
  logic fifo_in_ready;
  logic fifo_out_valid;
  wire pop_ready = !clear_s;
  wire pop = fifo_out_valid && pop_ready;

  // RULE3 capture whole register
  // RULE9 address then data
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pend_q <= 1'b0;
      ovf_q <= 1'b0;
      cap_q <= '0;
    end else if (latch_edge) begin
      pend_q <= 1'b1;
      ovf_q <= ovf_q || (pend_q && !fifo_in_ready);
      cap_q <= cdsp_frame_type'(shift_q);
    end else if (fifo_in_ready) begin
      pend_q <= 1'b0;
    end
  end
  assign overflow_out = ovf_q;

  cdsp_fifo #(
    .WIDTH(`CDSP_FRAME_BITS),
    .DEPTH(`CDSP_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(sys_clk_in),
    .nrst_in(nrst_in),
    .in_valid_in(pend_q),
    .in_ready_out(fifo_in_ready),
    .in_data_in(cap_q),
    .out_valid_out(fifo_out_valid),
    .out_ready_in(pop_ready),
    .out_data_out(pop_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  wire is_data = pop && (pop_word.addr == `CDSP_ADDR_DATA);
  wire is_read = pop && (pop_word.addr == `CDSP_ADDR_READ);
  wire is_ctrl = pop && (pop_word.addr == `CDSP_ADDR_CTRL);
  wire is_rst = pop && (pop_word.addr == `CDSP_ADDR_RESET)
    && pop_word.data[`CDSP_RESET_BIT];
  logic [`CDSP_DATA_BITS-1:0] data_q;
  logic [`CDSP_DATA_BITS-1:0] ctrl_q;
  cdsp_fault_type flt;
  assign flt = '{overtemp: ot_sync_q[1], open_loop: oc_sync_q[1]};
  wire [1:0] rb_sel = pop_word.data[1:0];
  wire [`CDSP_DATA_BITS-1:0] rb_next = (rb_sel == `CDSP_RB_DATA) ? data_q :
    (rb_sel == `CDSP_RB_CTRL) ? ctrl_q : `CDSP_DATA_BITS'(flt);

  // RULE10 register writes
  // RULE5 clear forces low end
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      data_q <= `CDSP_DATA_RST;
      ctrl_q <= `CDSP_CTRL_RST;
    end else if (is_rst) begin
      data_q <= `CDSP_DATA_RST;
      ctrl_q <= `CDSP_CTRL_RST;
    end else begin
      if (clear_s) data_q <= '0;
      else if (is_data) data_q <= pop_word.data;
      if (is_ctrl) ctrl_q <= pop_word.data;
    end
  end

  // Serial output mode and readback word
  always_ff @(posedge sys_clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mode_q <= MODE_WRITE;
      rb_tgl_q <= 1'b0;
      rb_word_q <= '0;
    end else if (pop) begin
      if (is_read) begin
        rb_tgl_q <= !rb_tgl_q;
        rb_word_q <= rb_next;
      end
      case (1'b1)
        is_read: mode_q <= MODE_READBACK;
        is_rst: mode_q <= MODE_WRITE;
        is_ctrl && pop_word.data[`CDSP_CTRL_DAISY_BIT]: mode_q <= MODE_DAISY;
        is_ctrl: mode_q <= MODE_WRITE; // New control word ends daisy mode at once
        default: mode_q <= ctrl_q[`CDSP_CTRL_DAISY_BIT] ? MODE_DAISY : MODE_WRITE;
      endcase
    end
  end

  assign dac_code_out = data_q;
  assign range_out = ctrl_q[`CDSP_CTRL_RANGE_MSB:`CDSP_CTRL_RANGE_LSB];
  assign out_enable_out = ctrl_q[`CDSP_CTRL_OUTEN_BIT];
  // RULE6 open-drain fault
  assign fault_n_out = 1'b0;
  assign fault_n_oe_out = flt.overtemp || (flt.open_loop && out_enable_out);

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  localparam int CLR_MAX = CLEAR_CYC;
  chk_shift_in: assert property (@(posedge serial_clk_in) disable iff (!nrst_in) // RULE1
    !load_req |=> shift_q[0] == $past(serial_in_line_in)
      && shift_q[23:1] == $past(shift_q[22:0]))
    else $error("shift register did not take serial input");
  chk_commit_data: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RULE3
    is_data && !is_rst |=> data_q == $past(pop_word.data))
    else $error("data word not committed");
  chk_out_fall: assert property (@(posedge serial_clk_in) disable iff (!nrst_in) // RULE4
    sdo_bit_q == shift_q[23])
    else $error("serial output bit not from shift register");
  chk_clear_force: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RULE5
    $rose(clear_in) ##1 clear_in[*2] |-> ##[0:CLR_MAX] dac_code_out == '0)
    else $error("clear did not force low end");
  chk_fault_pull: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RULE6
    overtemp_in[*3] |-> fault_n_oe_out && !fault_n_out)
    else $error("fault flag not pulled low");
  chk_out_release: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RULE8
    latch_in |-> !serial_out_line_oe_out)
    else $error("serial output still driven while latch high");
  chk_frame_split: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RULE9
    latch_edge |=> cap_q.addr == $past(shift_q[23:16]) && cap_q.data == $past(shift_q[15:0]))
    else $error("frame fields misplaced");
  chk_nop_decode: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RULE10
    pop && pop_word.addr == `CDSP_ADDR_NOP |=> $stable(ctrl_q))
    else $error("no-operation frame changed control");
  chk_latch_commit: assert property (@(posedge sys_clk_in) disable iff (!nrst_in) // RULE11
    $rose(latch_in) ##1 latch_in |-> ##[1:3] pend_q)
    else $error("latch edge did not commit a frame");
endmodule : cdsp_port

// *** cdsp_map.svh ***
`ifndef CDSP_MAP_SVH
`define CDSP_MAP_SVH
// Frame layout
`define CDSP_FRAME_BITS 24
`define CDSP_ADDR_BITS 8
`define CDSP_DATA_BITS 16
// Address word codes
`define CDSP_ADDR_NOP 8'h00
`define CDSP_ADDR_DATA 8'h01
`define CDSP_ADDR_READ 8'h02
`define CDSP_ADDR_CTRL 8'h55
`define CDSP_ADDR_RESET 8'h56
// Control word fields
`define CDSP_CTRL_RANGE_LSB 0
`define CDSP_CTRL_RANGE_MSB 2
`define CDSP_CTRL_DAISY_BIT 3
`define CDSP_CTRL_OUTEN_BIT 12
`define CDSP_RESET_BIT 0
// Readback select codes
`define CDSP_RB_STATUS 2'h0
`define CDSP_RB_DATA 2'h1
`define CDSP_RB_CTRL 2'h2
// Reset values
`define CDSP_DATA_RST 16'h0000
`define CDSP_CTRL_RST 16'h0000
// Timing
`define CDSP_SYS_PERIOD_NS 40
`define CDSP_CLEAR_ACT_NS 5000
`define CDSP_CLEAR_ACT_CYC (`CDSP_CLEAR_ACT_NS / `CDSP_SYS_PERIOD_NS)
`define CDSP_FIFO_DEPTH 4
`endif

// *** cdsp_pkg.sv ***
`include "cdsp_map.svh"
package cdsp_pkg;
  // One committed serial frame
  typedef struct packed {
    logic [`CDSP_ADDR_BITS-1:0] addr;
    logic [`CDSP_DATA_BITS-1:0] data;
  } cdsp_frame_type;
  // Serial output behaviour
  typedef enum logic [2:0] {
    MODE_WRITE = 3'b001,
    MODE_READBACK = 3'b010,
    MODE_DAISY = 3'b100
  } cdsp_mode_type;
  // Fault sources
  typedef struct packed {
    logic overtemp;
    logic open_loop;
  } cdsp_fault_type;
endpackage : cdsp_pkg

// *** cdsp_host_model.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// Host end of the serial link
module cdsp_host_model (
  output logic serial_clk_out,
  output logic serial_data_out,
  output logic latch_out,
  input wire logic sdo_in
);
  logic [31:0] rx_q;
  // Idle levels; serial clock stands still between frames
  initial begin
    serial_clk_out = 1'b0;
    serial_data_out = 1'b0;
    latch_out = 1'b0;
    rx_q = 32'h0;
  end
  // MSB first, latch low until after the last rising edge
  // data changes at falling edges and before the first rising edge, stable at rising ones
  task automatic frame(input logic [31:0] word, input int nbits);
    latch_out = 1'b0;
    #41;
    for (int i = nbits - 1; i >= 0; i--) begin
      serial_data_out = word[i];
      #3 serial_clk_out = 1'b1;
      rx_q = {rx_q[30:0], sdo_in}; // Readback sample
      #3 serial_clk_out = 1'b0;
    end
    // Released line shows the inverse of its last bit
    serial_data_out = ~serial_data_out;
    #3 latch_out = 1'b1;
  endtask : frame
endmodule : cdsp_host_model

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  import cdsp_pkg::*;
  logic sys_clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic clear_in = 1'b0;
  logic open_loop_in = 1'b0;
  logic overtemp_in = 1'b0;
  logic sclk, serial_in_line, latch, serial_out_line, sdo_oe, sdo_wire, flt_n, flt_oe, out_en, ovf;
  logic [15:0] dac;
  logic [2:0] range;
  int bad_count = 0;
  int tests_run = 0;
  int cycles = 0;
  // Undriven output line seen by the host as the inverse of the serial output bit
  assign sdo_wire = sdo_oe ? serial_out_line : ~serial_out_line;
  cdsp_port #(.CLEAR_CYC(8)) i_cdsp_port (.sys_clk_in(sys_clk_in), .nrst_in(nrst_in),
    .serial_clk_in(sclk), .serial_in_line_in(serial_in_line), .latch_in(latch), .clear_in(clear_in),
    .open_loop_in(open_loop_in), .overtemp_in(overtemp_in), .serial_out_line_out(serial_out_line),
    .serial_out_line_oe_out(sdo_oe), .fault_n_out(flt_n), .fault_n_oe_out(flt_oe),
    .dac_code_out(dac), .range_out(range), .out_enable_out(out_en), .overflow_out(ovf));
  cdsp_host_model i_cdsp_host_model (.serial_clk_out(sclk), .serial_data_out(serial_in_line),
    .latch_out(latch), .sdo_in(sdo_wire));
  always #20 sys_clk_in = ~sys_clk_in;
  ////////////////////////////////////////////////////////////////////////////////
  // Compare and report
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic final_report;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : final_report
  // Hang guard
  always @(posedge sys_clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      bad_count++;
      final_report();
    end
  end
  task automatic waitc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : waitc
  // latch held high for the given time after each frame
  task automatic send(input logic [31:0] w, input int nbits, input int hold_ns);
    i_cdsp_host_model.frame(w, nbits);
    #(hold_ns);
    waitc(8);
  endtask : send
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_reset;
    check("dac", dac, 16'h0000);
    check("status", {10'h0, range, out_en, flt_oe, ovf}, 16'h0000);
  endtask : t_reset
  task automatic t_write;
    send({8'hFF, 8'h01, 16'hA5C3}, 32, 200);
    check("dac", dac, 16'hA5C3);
    send({8'h00, 8'h00, 16'h1234}, 24, 200);
    check("nop", dac, 16'hA5C3);
  endtask : t_write
  task automatic t_ctrl;
    send({8'h00, 8'h55, 16'h1005}, 24, 5000);
    check("ctrl", {12'h0, range, out_en}, 16'h000B);
  endtask : t_ctrl
  task automatic t_fault;
    open_loop_in <= 1'b1;
    waitc(4);
    check("fault open", {flt_oe, flt_n}, 16'h0002);
    open_loop_in <= 1'b0;
    overtemp_in <= 1'b1;
    waitc(4);
    check("fault temp", {flt_oe, flt_n}, 16'h0002);
    overtemp_in <= 1'b0;
    waitc(4);
    check("fault off", {flt_oe, flt_n}, 16'h0000);
  endtask : t_fault
  task automatic t_daisy;
    send({8'h00, 8'h55, 16'h1008}, 24, 5000);
    send({8'hC3, 24'h000000}, 32, 200);
    // Low byte of the old frame, then the first byte of the new one
    check("daisy out", i_cdsp_host_model.rx_q[15:0], 16'h08C3);
  endtask : t_daisy
  task automatic t_readback;
    send({8'h00, 8'h02, 16'h0001}, 24, 200);
    i_cdsp_host_model.frame(32'h0, 32);
    #30;
    check("sdo oe", sdo_oe, 16'h0000);
    check("readback", i_cdsp_host_model.rx_q[20:5], 16'hA5C3);
    #200;
    send({8'h00, 8'h56, 16'h0001}, 24, 5000);
    check("reset data", dac, 16'h0000);
    check("reset ctrl", {12'h0, range, out_en}, 16'h0000);
  endtask : t_readback
  task automatic t_clear_fill;
    send({8'h00, 8'h01, 16'h5AA5}, 24, 200);
    check("pre clear", dac, 16'h5AA5);
    clear_in <= 1'b1;
    waitc(4);
    check("clear", dac, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      send({8'h00, 8'h01, 16'h1110 + 16'(i)}, 24, 200);
    end
    check("clear hold", dac, 16'h0000);
    // Fifth frame is lost, the newest one stays pending
    check("overflow", {15'h0, ovf}, 16'h0001);
    clear_in <= 1'b0;
    waitc(16);
    check("drained", dac, 16'h1115);
  endtask : t_clear_fill
  initial begin
    waitc(10);
    nrst_in <= 1'b1;
    waitc(4);
    t_reset();
    t_write();
    t_ctrl();
    t_fault();
    t_daisy();
    t_readback();
    t_clear_fill();
    final_report();
  end
endmodule : tb
